// *** design/prm_params.svh ***
// Constants of the pulse-rate meter front-panel block
`ifndef PRM_PARAMS_SVH
`define PRM_PARAMS_SVH
`define PRM_CLK_HZ          10000000
`define PRM_MS_CYC(ms)      ((ms) * (`PRM_CLK_HZ / 1000))
`define PRM_INIT_HOLD_MS    3000
`define PRM_RET_HOLD_MS     1000
`define PRM_RESTORE_HOLD_MS 3000
`define PRM_GATE_MS         1000
`define PRM_BLINK_MS        500
`define PRM_RANGE_SLOW_HZ   30
`define PRM_RANGE_FAST_HZ   5000
`define PRM_FILT_CYC(hz)    (`PRM_CLK_HZ / (4 * (hz)))
`define PRM_FRAC_BITS       16
`define PRM_DIV_STEPS       6'h21
`define PRM_HALF_LSB        49'h0_0000_0000_8000
`define PRM_DISP_MAX        33'h0_0001_869F
`define PRM_DISP_NEG_MAX    33'h0_0000_4E1F
`define PRM_DEF_SCALE_IN    17'h0_0001
`define PRM_DEF_SCALE_DISP  18'h0_0001
`define PRM_A_CTRL          8'h00
`define PRM_A_CFG           8'h04
`define PRM_A_SCALE_IN      8'h08
`define PRM_A_SCALE_DISP    8'h0C
`define PRM_A_SETPT1        8'h10
`define PRM_A_SETPT2        8'h14
`define PRM_A_ADV_A         8'h18
`define PRM_A_ADV_B         8'h1C
`define PRM_A_STATUS        8'h20
`define PRM_A_DISPLAY       8'h24
`define PRM_A_FREQ          8'h28
`define PRM_A_FACTOR        8'h2C
`define PRM_CTRL_LOCK       0
`define PRM_CFG_RANGE       0
`define PRM_CFG_DP          3:1
`define PRM_ADVA_AVG        3:0
`define PRM_ADVA_HYS        11:4
`define PRM_ADVA_AZERO      19:12
`define PRM_ADVA_STCOMP     27:20
`define PRM_ADVB_COLOUR     1:0
`define PRM_ADVB_ARET       9:2
`define PRM_ADVB_PTIME      17:10
`define PRM_RESP_OKAY       2'h0
`define PRM_RESP_SLVERR     2'h2
`define PRM_RESP_DECERR     2'h3
`endif

// *** design/prm_pkg.sv ***
// Types shared by the pulse-rate meter front-panel block
`include "prm_params.svh"
package prm_pkg;
  typedef enum logic [3:0] {
    PRM_OPER = 4'h1,
    PRM_INIT = 4'h2,
    PRM_ADV  = 4'h4,
    PRM_MERR = 4'h8
  } prm_level_e;

  typedef struct packed {
    logic              lock;
    logic              range_fast;
    logic [2:0]        dp;
    logic [16:0]       scale_in;
    logic signed [17:0] scale_disp;
    logic signed [17:0] setpt1;
    logic signed [17:0] setpt2;
    logic [3:0]        avg_cnt;
    logic [7:0]        hyst;
    logic [7:0]        azero;
    logic [7:0]        stcomp;
    logic [1:0]        colour;
    logic [7:0]        aret;
    logic [7:0]        ptime;
  } prm_cfg_s;

  localparam prm_cfg_s PRM_CFG_DEF = '{
    scale_in:   `PRM_DEF_SCALE_IN,
    scale_disp: `PRM_DEF_SCALE_DISP,
    default:    '0
  };

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } prm_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } prm_axi_rsp_s;

  typedef struct packed {
    logic signed [17:0] value;
    logic [2:0]         dp;
    logic               blank;
    logic               err;
    logic               over;
    logic               under;
  } prm_disp_s;
endpackage

// *** design/prm_div.sv ***
// Restoring divider that turns the scaling pair into a prescale factor
`timescale 1ns/1ns
`include "prm_params.svh"
module prm_div
  import prm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [16:0] num,
  input  wire logic [16:0] den,
  output logic             busy,
  output logic             done,
  output logic [32:0]      quo
);
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [17:0] rem;
    logic [32:0] qs;
    logic [16:0] den;
  } prm_div_st_s;

  prm_div_st_s s_q;
  prm_div_st_s s_d;
  logic [17:0] rem_sh;
  logic [32:0] q_sh;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    rem_sh = {s_q.rem[16:0], s_q.qs[32]};
    q_sh = {s_q.qs[31:0], 1'b0};
    if (start && !s_q.busy)
    begin
      // Fractional bits keep rounding error small
      s_d.busy = 1'b1;
      s_d.cnt = `PRM_DIV_STEPS;
      s_d.rem = '0;
      s_d.qs = {num, 16'h0000};
      s_d.den = den;
    end
    else if (s_q.busy)
    begin
      if (rem_sh >= {1'b0, s_q.den})
      begin
        rem_sh = rem_sh - {1'b0, s_q.den};
        q_sh[0] = 1'b1;
      end
      s_d.rem = rem_sh;
      s_d.qs = q_sh;
      s_d.cnt = s_q.cnt - 6'h01;
      if (s_q.cnt == 6'h01)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end

  assign busy = s_q.busy;
  assign done = s_q.done;
  assign quo  = s_q.qs;
endmodule

// *** design/prm_freq.sv ***
// Pulse input filter and one-second gate frequency counter
`timescale 1ns/1ns
`include "prm_params.svh"
module prm_freq
  import prm_pkg::*;
#(
  parameter int unsigned GATE_CYC      = `PRM_MS_CYC(`PRM_GATE_MS),
  parameter int unsigned FILT_SLOW_CYC = `PRM_FILT_CYC(`PRM_RANGE_SLOW_HZ)
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        en,
  input  wire logic        range_fast,
  input  wire logic        pulse_in,
  output logic [15:0]      freq,
  output logic             fvalid
);
  typedef struct packed {
    logic        raw;
    logic        lvl;
    logic [16:0] stab;
    logic [23:0] gate;
    logic [15:0] edges;
    logic [15:0] freq;
    logic        vld;
  } prm_freq_st_s;

  prm_freq_st_s s_q;
  prm_freq_st_s s_d;
  logic [16:0]  filt;
  logic [15:0]  edges_nx;

  always_comb
  begin
    s_d = s_q;
    s_d.vld = 1'b0;
    s_d.raw = pulse_in;
    // Longer filter on the slow range rejects contact bounce
    filt = range_fast ? 17'(`PRM_FILT_CYC(`PRM_RANGE_FAST_HZ))
                      : 17'(FILT_SLOW_CYC);
    if (pulse_in != s_q.raw)
      s_d.stab = '0;
    else if (s_q.stab < filt)
      s_d.stab = s_q.stab + 17'h0_0001;
    edges_nx = s_q.edges;
    if (s_q.stab >= filt && s_q.raw != s_q.lvl)
    begin
      s_d.lvl = s_q.raw;
      if (s_q.raw && s_q.edges != 16'hFFFF)
        edges_nx = s_q.edges + 16'h0001;
    end
    if (!en)
    begin
      s_d.gate = '0;
      s_d.edges = '0;
    end
    else if (s_q.gate == 24'(GATE_CYC - 1))
    begin
      s_d.gate = '0;
      s_d.freq = edges_nx;
      s_d.edges = '0;
      s_d.vld = 1'b1;
    end
    else
    begin
      s_d.gate = s_q.gate + 24'h00_0001;
      s_d.edges = edges_nx;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end

  assign freq   = s_q.freq;
  assign fvalid = s_q.vld;
endmodule

// *** design/prm_top.sv ***
// Pulse-rate meter front panel: levels, scaling, display, registers
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "prm_params.svh"
module prm_top
  import prm_pkg::*;
#(
  parameter int unsigned HOLD_INIT_CYC    = `PRM_MS_CYC(`PRM_INIT_HOLD_MS),
  parameter int unsigned HOLD_RET_CYC     = `PRM_MS_CYC(`PRM_RET_HOLD_MS),
  parameter int unsigned HOLD_RESTORE_CYC = `PRM_MS_CYC(`PRM_RESTORE_HOLD_MS),
  parameter int unsigned GATE_CYC         = `PRM_MS_CYC(`PRM_GATE_MS),
  parameter int unsigned BLINK_CYC        = `PRM_MS_CYC(`PRM_BLINK_MS),
  parameter int unsigned FILT_SLOW_CYC    = `PRM_FILT_CYC(`PRM_RANGE_SLOW_HZ)
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire prm_axi_req_s axi_req,
  output prm_axi_rsp_s      axi_rsp,
  input  wire logic         level_key,
  input  wire logic         adv_key,
  input  wire logic         nvm_err,
  input  wire logic         pulse_in,
  output prm_disp_s         disp,
  output prm_level_e        level,
  output logic              measuring
);
  typedef struct packed {
    logic         aw_got;
    logic [7:0]   aw_addr;
    logic         w_got;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    prm_axi_rsp_s rsp;
    prm_cfg_s     cfg;
    prm_level_e   lvl;
    logic [24:0]  hold_cnt;
    logic         hold_fired;
    logic         adv_q;
    logic         calc_req;
    logic [32:0]  factor;
    logic         fsign;
    prm_disp_s    disp;
    logic [22:0]  blink_cnt;
    logic         blink;
    logic         meas;
  } prm_top_st_s;

  localparam prm_top_st_s ST_RST = '{
    cfg:      PRM_CFG_DEF,
    lvl:      PRM_OPER,
    calc_req: 1'b1,
    meas:     1'b1,
    default:  '0
  };

  prm_top_st_s s_q;
  prm_top_st_s s_d;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [32:0] rd_hit;
  logic [24:0] hold_nx;
  logic        unlocked;
  logic        div_start;
  logic        div_busy;
  logic        div_done;
  logic [32:0] div_quo;
  logic [15:0] fq;
  logic        fq_vld;
  logic [48:0] prod;
  logic [32:0] mag;
  logic        over;
  logic        under;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_mask
      assign wmask[g*8 +: 8] = {8{s_q.wstrb[g]}};
    end
  endgenerate

  // Top bit flags a mapped address; low word is the readback
  function automatic logic [32:0] rd_word(input logic [7:0] a,
                                          input prm_top_st_s st,
                                          input logic [15:0] f);
    logic [32:0] r;
    r = '0;
    case (a)
      `PRM_A_CTRL:       r = {1'b1, 31'h0, st.cfg.lock};
      `PRM_A_CFG:        r = {1'b1, 28'h0, st.cfg.dp, st.cfg.range_fast};
      `PRM_A_SCALE_IN:   r = {1'b1, 15'h0, st.cfg.scale_in};
      `PRM_A_SCALE_DISP: r = {1'b1, 32'(st.cfg.scale_disp)};
      `PRM_A_SETPT1:     r = {1'b1, 32'(st.cfg.setpt1)};
      `PRM_A_SETPT2:     r = {1'b1, 32'(st.cfg.setpt2)};
      `PRM_A_ADV_A:      r = {1'b1, 4'h0, st.cfg.stcomp, st.cfg.azero,
                              st.cfg.hyst, st.cfg.avg_cnt};
      `PRM_A_ADV_B:      r = {1'b1, 14'h0, st.cfg.ptime, st.cfg.aret,
                              st.cfg.colour};
      `PRM_A_STATUS:     r = {1'b1, 23'h0, st.calc_req, st.disp.under,
                              st.disp.over, st.disp.err, st.meas,
                              st.lvl};
      `PRM_A_DISPLAY:    r = {1'b1, 32'(st.disp.value)};
      `PRM_A_FREQ:       r = {1'b1, 16'h0, f};
      `PRM_A_FACTOR:     r = {1'b1, st.factor[31:0]};
      default:           r = '0;
    endcase
    return r;
  endfunction

  always_comb
  begin
    s_d = s_q;
    rd_hit = '0;
    wval = '0;
    unlocked = !s_q.cfg.lock;
    div_start = s_q.calc_req && !div_busy;
    prod = '0;
    mag = '0;
    over = 1'b0;
    under = 1'b0;

    // Factor recompute; a new scaling write re-arms the request
    if (div_start)
    begin
      s_d.calc_req = 1'b0;
      s_d.fsign = s_q.cfg.scale_disp[17];
    end
    if (div_done)
      s_d.factor = div_quo;

    // Write channel: address and data taken in either order
    if (axi_req.awvalid && s_q.rsp.awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.rsp.wready)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    if (s_q.rsp.bvalid && axi_req.bready)
      s_d.rsp.bvalid = 1'b0;
    if (s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = `PRM_RESP_SLVERR;
      rd_hit = rd_word(s_q.aw_addr, s_q, fq);
      wval = (rd_hit[31:0] & ~wmask) | (s_q.wdata & wmask);
      case (s_q.aw_addr)
        `PRM_A_CTRL:
        begin
          // Protect-level lock bit is never itself locked
          s_d.cfg.lock = wval[`PRM_CTRL_LOCK];
          s_d.rsp.bresp = `PRM_RESP_OKAY;
        end
        `PRM_A_CFG:
          if (unlocked && s_q.lvl == PRM_INIT)
          begin
            s_d.cfg.range_fast = wval[`PRM_CFG_RANGE];
            s_d.cfg.dp = wval[`PRM_CFG_DP];
            s_d.rsp.bresp = `PRM_RESP_OKAY;
          end
        `PRM_A_SCALE_IN:
          if (unlocked && s_q.lvl == PRM_INIT && wval[16:0] != '0)
          begin
            s_d.cfg.scale_in = wval[16:0];
            s_d.calc_req = 1'b1;
            s_d.rsp.bresp = `PRM_RESP_OKAY;
          end
        `PRM_A_SCALE_DISP:
          if (unlocked && s_q.lvl == PRM_INIT)
          begin
            s_d.cfg.scale_disp = wval[17:0];
            s_d.calc_req = 1'b1;
            s_d.rsp.bresp = `PRM_RESP_OKAY;
          end
        `PRM_A_SETPT1:
          if (unlocked && s_q.lvl == PRM_OPER)
          begin
            s_d.cfg.setpt1 = wval[17:0];
            s_d.rsp.bresp = `PRM_RESP_OKAY;
          end
        `PRM_A_SETPT2:
          if (unlocked && s_q.lvl == PRM_OPER)
          begin
            s_d.cfg.setpt2 = wval[17:0];
            s_d.rsp.bresp = `PRM_RESP_OKAY;
          end
        `PRM_A_ADV_A:
          if (unlocked && s_q.lvl == PRM_ADV)
          begin
            s_d.cfg.avg_cnt = wval[`PRM_ADVA_AVG];
            s_d.cfg.hyst = wval[`PRM_ADVA_HYS];
            s_d.cfg.azero = wval[`PRM_ADVA_AZERO];
            s_d.cfg.stcomp = wval[`PRM_ADVA_STCOMP];
            s_d.rsp.bresp = `PRM_RESP_OKAY;
          end
        `PRM_A_ADV_B:
          if (unlocked && s_q.lvl == PRM_ADV)
          begin
            s_d.cfg.colour = wval[`PRM_ADVB_COLOUR];
            s_d.cfg.aret = wval[`PRM_ADVB_ARET];
            s_d.cfg.ptime = wval[`PRM_ADVB_PTIME];
            s_d.rsp.bresp = `PRM_RESP_OKAY;
          end
        default:
          if (!rd_hit[32])
            s_d.rsp.bresp = `PRM_RESP_DECERR;
      endcase
    end

    // Read channel: one read in flight
    if (s_q.rsp.rvalid && axi_req.rready)
      s_d.rsp.rvalid = 1'b0;
    if (axi_req.arvalid && s_q.rsp.arready)
    begin
      rd_hit = rd_word(axi_req.araddr, s_q, fq);
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata = rd_hit[31:0];
      s_d.rsp.rresp = rd_hit[32] ? `PRM_RESP_OKAY : `PRM_RESP_DECERR;
    end

    // Level key hold timer; fires once per press
    if (level_key)
    begin
      if (s_q.hold_cnt != '1)
        s_d.hold_cnt = s_q.hold_cnt + 25'h000_0001;
    end
    else
    begin
      s_d.hold_cnt = '0;
      s_d.hold_fired = 1'b0;
    end
    hold_nx = s_d.hold_cnt;
    s_d.adv_q = adv_key;

    case (s_q.lvl)
      PRM_OPER:
        if (!s_q.hold_fired && hold_nx == 25'(HOLD_INIT_CYC))
        begin
          s_d.lvl = PRM_INIT;
          s_d.hold_fired = 1'b1;
        end
      PRM_INIT, PRM_ADV:
        if (!s_q.hold_fired && hold_nx == 25'(HOLD_RET_CYC + 1))
        begin
          s_d.lvl = PRM_OPER;
          s_d.hold_fired = 1'b1;
        end
        else if (adv_key && !s_q.adv_q)
          s_d.lvl = (s_q.lvl == PRM_INIT) ? PRM_ADV : PRM_INIT;
      PRM_MERR:
        if (!s_q.hold_fired && hold_nx == 25'(HOLD_RESTORE_CYC))
        begin
          // Restore beats any bus write landing in the same cycle
          s_d.cfg = PRM_CFG_DEF;
          s_d.calc_req = 1'b1;
          s_d.lvl = PRM_OPER;
          s_d.hold_fired = 1'b1;
        end
      default:
        s_d.lvl = PRM_OPER;
    endcase
    // A live error keeps the error level; detection wins over restore
    if (nvm_err)
      s_d.lvl = PRM_MERR;
    s_d.meas = (s_d.lvl == PRM_OPER);

    // Scaling of each gated frequency sample
    prod = 49'(fq) * 49'(s_q.factor) + `PRM_HALF_LSB;
    mag = prod[48:16];
    if (fq_vld)
    begin
      over = !s_q.fsign && mag > `PRM_DISP_MAX;
      under = s_q.fsign && mag > `PRM_DISP_NEG_MAX;
      s_d.disp.over = over;
      s_d.disp.under = under;
      if (over)
        s_d.disp.value = 18'(`PRM_DISP_MAX);
      else if (under)
        s_d.disp.value = -$signed(18'(`PRM_DISP_NEG_MAX));
      else if (s_q.fsign)
        s_d.disp.value = -$signed(mag[17:0]);
      else
        s_d.disp.value = mag[17:0];
    end

    // Flash timer; limited values blink at a fixed rate
    if (s_q.blink_cnt == 23'(BLINK_CYC - 1))
    begin
      s_d.blink_cnt = '0;
      s_d.blink = !s_q.blink;
    end
    else
      s_d.blink_cnt = s_q.blink_cnt + 23'h00_0001;
    s_d.disp.blank = (s_d.disp.over || s_d.disp.under) && s_d.blink;
    s_d.disp.dp = s_d.cfg.dp;
    s_d.disp.err = (s_d.lvl == PRM_MERR);

    s_d.rsp.awready = !s_d.aw_got && !s_d.rsp.bvalid;
    s_d.rsp.wready = !s_d.w_got && !s_d.rsp.bvalid;
    s_d.rsp.arready = !s_d.rsp.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= ST_RST;
    else if (ce)
      s_q <= s_d;
  end

  prm_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .start   (div_start),
    .num     (s_q.cfg.scale_disp[17] ? 17'(-s_q.cfg.scale_disp)
                                     : s_q.cfg.scale_disp[16:0]),
    .den     (s_q.cfg.scale_in),
    .busy    (div_busy),
    .done    (div_done),
    .quo     (div_quo)
  );

  prm_freq #(
    .GATE_CYC      (GATE_CYC),
    .FILT_SLOW_CYC (FILT_SLOW_CYC)
  ) u_freq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .en         (s_q.meas),
    .range_fast (s_q.cfg.range_fast),
    .pulse_in   (pulse_in),
    .freq       (fq),
    .fvalid     (fq_vld)
  );

  assign axi_rsp   = s_q.rsp;
  assign disp      = s_q.disp;
  assign level     = s_q.lvl;
  assign measuring = s_q.meas;
endmodule

// *** verification/prm_panel_model.sv ***
// Operator level key and pulse sensor model
`timescale 1ns/1ns
module prm_panel_model (
  input  wire logic       aclk,
  input  wire logic       press_go,
  input  wire logic [7:0] press_len,
  input  wire logic       pulse_en,
  input  wire logic [7:0] half_per,
  output logic            level_key,
  output logic            pulse_in
);
  logic [7:0] key_q = 8'h00;
  logic [7:0] ph_q  = 8'h00;
  initial pulse_in = 1'b0;
  // Key held for exactly press_len edges, then released
  assign level_key = (key_q != 8'h00);
  always @(posedge aclk)
  begin
    if (press_go)
      key_q <= press_len;
    else if (key_q != 8'h00)
      key_q <= key_q - 8'h01;
    // Idle sensor line rests low, as an open output pulled down
    if (!pulse_en)
    begin
      ph_q <= 8'h00;
      pulse_in <= 1'b0;
    end
    else if (ph_q + 8'h01 >= half_per)
    begin
      ph_q <= 8'h00;
      pulse_in <= ~pulse_in;
    end
    else
      ph_q <= ph_q + 8'h01;
  end
endmodule

// *** verification/prm_top_asserts.sv ***
// Port-level property checker of the front-panel block
`timescale 1ns/1ns
module prm_top_asserts
  import prm_pkg::*;
#(
  parameter int unsigned HOLD_INIT_CYC = 40,
  parameter int unsigned HOLD_RET_CYC  = 20
)(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         ce,
  input wire prm_axi_req_s axi_req,
  input wire prm_axi_rsp_s axi_rsp,
  input wire logic         level_key,
  input wire logic         adv_key,
  input wire logic         nvm_err,
  input wire logic         pulse_in,
  input wire prm_disp_s    disp,
  input wire prm_level_e   level,
  input wire logic         measuring
);
  int unsigned key_cnt_q;
  // Own count of held edges, so level moves are judged independently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      key_cnt_q <= 0;
    else if (ce)
      key_cnt_q <= level_key ? key_cnt_q + 1 : 0;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_meas_level: assert property (measuring == (level == PRM_OPER))
    else $error("measuring flag disagrees with level");
  a_disp_frozen: assert property (!measuring [*3] |-> $stable(disp.value))
    else $error("display changed while measurement suspended");
  a_init_hold: assert property (level == PRM_INIT && $past(level) == PRM_OPER
    |-> key_cnt_q >= HOLD_INIT_CYC)
    else $error("initial level entered on a short press");
  a_ret_hold: assert property (level == PRM_OPER && ($past(level) == PRM_INIT
    || $past(level) == PRM_ADV) |-> key_cnt_q > HOLD_RET_CYC)
    else $error("operation level entered on a short press");
  a_merr_entry: assert property (ce && nvm_err |=> level == PRM_MERR)
    else $error("memory error did not force error level");
  a_err_shown: assert property (level == PRM_MERR [*3] |-> disp.err)
    else $error("error code not shown in error level");
  a_over_clip: assert property (disp.over
    |-> disp.value == 18'h1869F && !disp.under)
    else $error("overrange value not clipped");
  a_under_clip: assert property (disp.under |-> disp.value == 18'h3B1E1)
    else $error("underrange value not clipped");
  a_blank_lim: assert property (!(disp.over || disp.under) [*2]
    |-> !disp.blank)
    else $error("indicator blanked outside a limit");
endmodule

// *** verification/test_pulse_rate_meter_setup_scaling.sv ***
// Self-checking bench of the pulse-rate meter front panel
`timescale 1ns/1ns
`include "prm_params.svh"
module test_pulse_rate_meter_setup_scaling
  import prm_pkg::*;
;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  prm_axi_req_s axi_req = '0;
  prm_axi_rsp_s axi_rsp;
  logic         adv_key = 1'b0;
  logic         nvm_err = 1'b0;
  logic         press_go = 1'b0;
  logic         ce = 1'b1;
  logic         pulse_en = 1'b1;
  logic [7:0]   half_per = 8'h0A;
  logic [7:0]   press_len = 8'h00;
  logic         level_key;
  logic         pulse_in;
  prm_disp_s    disp;
  prm_level_e   level;
  logic         measuring;
  logic [1:0]   rsp_q;
  logic         b_q;
  int           err_total = 0;
  int           checked = 0;
  initial forever #50 aclk = ~aclk;
  // Shortened hold and gate counts keep the run brief
  prm_top #(.HOLD_INIT_CYC(40), .HOLD_RET_CYC(20), .HOLD_RESTORE_CYC(40),
    .GATE_CYC(200), .BLINK_CYC(8), .FILT_SLOW_CYC(4)) prm_top_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .level_key(level_key), .adv_key(adv_key),
    .nvm_err(nvm_err), .pulse_in(pulse_in), .disp(disp), .level(level),
    .measuring(measuring));
  // Period 20 gives exactly ten pulses in any 200-cycle gate
  prm_panel_model prm_panel_model_i (.aclk(aclk), .press_go(press_go),
    .press_len(press_len), .pulse_en(pulse_en), .half_per(half_per),
    .level_key(level_key), .pulse_in(pulse_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] ex);
    checked++;
    if (seen !== ex)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, ex);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw;
    logic w;
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    b_q = 1'b0;
    for (int n = 0; n < 50 && !b_q; n++)
    begin
      @(negedge aclk);
      aw = axi_rsp.awready;
      w = axi_rsp.wready;
      b_q = axi_rsp.bvalid;
      rsp_q = axi_rsp.bresp;
      @(posedge aclk);
      if (aw)
        axi_req.awvalid <= 1'b0;
      // Valid drops after the edge where ready was seen, so the write is sent once
      if (w)
        axi_req.wvalid <= 1'b0;
    end
    if (!b_q)
    begin
      err_total++;
      give_verdict();
    end
    chk(32'(rsp_q), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    logic ar;
    logic [31:0] dat;
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    b_q = 1'b0;
    for (int n = 0; n < 50 && !b_q; n++)
    begin
      @(negedge aclk);
      ar = axi_rsp.arready;
      b_q = axi_rsp.rvalid;
      dat = axi_rsp.rdata;
      @(posedge aclk);
      if (ar)
        axi_req.arvalid <= 1'b0;
    end
    if (!b_q)
    begin
      err_total++;
      give_verdict();
    end
    chk(dat, ex);
  endtask
  task automatic press(input logic [7:0] n);
    press_len <= n;
    press_go <= 1'b1;
    @(posedge aclk);
    press_go <= 1'b0;
    repeat (int'(n) + 4) @(posedge aclk);
  endtask
  task automatic lvl(input prm_level_e e);
    @(negedge aclk);
    chk(32'(level), 32'(e));
    @(posedge aclk);
  endtask
  task automatic tap_adv();
    adv_key <= 1'b1;
    repeat (2) @(posedge aclk);
    adv_key <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  function automatic logic [31:0] exp_disp(input int si, input int sd,
                                           input int f);
    longint q;
    longint v;
    // Factor truncated to 16 fraction bits, display rounded
    q = (longint'(sd < 0 ? -sd : sd) * 65536) / si;
    v = (f * q + 32768) >>> 16;
    if (sd < 0)
      v = -v;
    if (v > 99999)
      v = 99999;
    if (v < -19999)
      v = -19999;
    return 32'(v);
  endfunction
  task automatic scale_run(input int si, input int sd);
    press(8'h28);
    wr(`PRM_A_SCALE_IN, 32'(si), `PRM_RESP_OKAY);
    wr(`PRM_A_SCALE_DISP, 32'(sd), `PRM_RESP_OKAY);
    press(8'h15);
    repeat (500) @(posedge aclk);
    rd(`PRM_A_DISPLAY, exp_disp(si, sd, 10));
  endtask
  initial
  begin
    logic bl;
    void'($urandom(62686));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    lvl(PRM_OPER);
    rd(`PRM_A_SCALE_IN, 32'h1);
    wr(`PRM_A_CTRL, 32'h1, `PRM_RESP_OKAY);
    wr(`PRM_A_SETPT1, 32'h5, `PRM_RESP_SLVERR);
    wr(`PRM_A_CTRL, 32'h0, `PRM_RESP_OKAY);
    wr(`PRM_A_SETPT1, 32'h5, `PRM_RESP_OKAY);
    rd(`PRM_A_SETPT1, 32'h5);
    press(8'h27);
    lvl(PRM_OPER);
    press(8'h28);
    lvl(PRM_INIT);
    wr(`PRM_A_CTRL, 32'h1, `PRM_RESP_OKAY);
    wr(`PRM_A_SCALE_IN, 32'h64, `PRM_RESP_SLVERR);
    wr(`PRM_A_CTRL, 32'h0, `PRM_RESP_OKAY);
    wr(`PRM_A_SCALE_IN, 32'h0, `PRM_RESP_SLVERR);
    wr(`PRM_A_CFG, 32'h1, `PRM_RESP_OKAY);
    rd(`PRM_A_CFG, 32'h1);
    wr(`PRM_A_CFG, 32'h4, `PRM_RESP_OKAY);
    rd(`PRM_A_CFG, 32'h4);
    wr(`PRM_A_SCALE_IN, 32'h64, `PRM_RESP_OKAY);
    wr(`PRM_A_SCALE_DISP, 32'h49A2, `PRM_RESP_OKAY);
    tap_adv();
    lvl(PRM_ADV);
    wr(`PRM_A_ADV_A, 32'hFFFFFFFF, `PRM_RESP_OKAY);
    rd(`PRM_A_ADV_A, 32'h0FFFFFFF);
    wr(`PRM_A_ADV_B, 32'hFFFFFFFF, `PRM_RESP_OKAY);
    rd(`PRM_A_ADV_B, 32'h0003FFFF);
    tap_adv();
    lvl(PRM_INIT);
    press(8'h14);
    lvl(PRM_INIT);
    press(8'h15);
    lvl(PRM_OPER);
    repeat (500) @(posedge aclk);
    rd(`PRM_A_DISPLAY, 32'h0000075D);
    rd(`PRM_A_FACTOR, 32'h00BC8000);
    @(negedge aclk);
    chk(32'(disp.dp), 32'h2);
    @(posedge aclk);
    // Frozen clock enable: a long press must not move the level
    ce <= 1'b0;
    press(8'h28);
    lvl(PRM_OPER);
    ce <= 1'b1;
    half_per <= 8'h14;
    repeat (500) @(posedge aclk);
    rd(`PRM_A_FREQ, 32'h5);
    rd(`PRM_A_DISPLAY, exp_disp(100, 18850, 5));
    pulse_en <= 1'b0;
    repeat (500) @(posedge aclk);
    rd(`PRM_A_DISPLAY, 32'h0);
    pulse_en <= 1'b1;
    half_per <= 8'h0A;
    for (int i = 0; i < 3; i++)
      scale_run(int'($urandom_range(1000, 1)), int'($urandom_range(9999, 0)));
    scale_run(1, 20000);
    @(negedge aclk);
    chk(32'(disp.over), 32'h1);
    bl = !disp.blank;
    repeat (8) @(negedge aclk);
    chk(32'(disp.blank), 32'(bl));
    @(posedge aclk);
    scale_run(1, -2000);
    @(negedge aclk);
    chk(32'(disp.under), 32'h1);
    @(posedge aclk);
    nvm_err <= 1'b1;
    @(posedge aclk);
    nvm_err <= 1'b0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(32'(level), 32'(PRM_MERR));
    chk(32'(disp.err), 32'h1);
    @(posedge aclk);
    press(8'h28);
    lvl(PRM_OPER);
    rd(`PRM_A_SCALE_IN, 32'h1);
    give_verdict();
  end
endmodule
bind prm_top prm_top_asserts #(.HOLD_INIT_CYC(HOLD_INIT_CYC),
  .HOLD_RET_CYC(HOLD_RET_CYC)) prm_top_asserts_i (.aclk(aclk),
  .aresetn(aresetn), .ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .level_key(level_key), .adv_key(adv_key), .nvm_err(nvm_err),
  .pulse_in(pulse_in), .disp(disp), .level(level), .measuring(measuring));
